// [hdl/hcfg_pkg.sv]
// Purpose: Shared constants for the haptic configuration and fault register slice
// Assumes: Byte-wide register port, 8-bit register addresses
// Notes:   Offsets are byte addresses on the register port
package hcfg_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] HBRIDGE_EDGE_TRIM_ADDR     = 8'h62;
	localparam logic [7:0] TOP_CONFIG_FIVE_ADDR       = 8'h6e;
	localparam logic [7:0] ACTUATOR_FAULT_EVENTS_ADDR = 8'h81;
	localparam logic [7:0] IRQ_STATUS_SECOND_ADDR     = 8'h82;
	localparam logic [7:0] IRQ_MASK_SECOND_ADDR       = 8'h83;
	localparam logic [7:0] SNIPPET_BYTE_FIRST_ADDR    = 8'h84;
	localparam logic [7:0] SNIPPET_BYTE_LAST_ADDR     = 8'he7;
	localparam int         SNIPPET_BYTES              = 100;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int EDGE_RATE_LSB      = 0;
	localparam int DELAY_BYPASS_BIT   = 2;
	localparam int FREQ_HOLD_BIT      = 1;
	localparam int OFFSET_ON_BIT      = 0;
	localparam int CLIP_EVENT_BIT     = 2;
	localparam int CLIP_LIVE_BIT      = 7;
	localparam int CLIP_MASK_BIT      = 7;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [1:0] EDGE_RATE_RST    = 2'h3;
	localparam logic       DELAY_BYPASS_RST = 1'h0;
	localparam logic       FREQ_HOLD_RST    = 1'h0;
	localparam logic       OFFSET_ON_RST    = 1'h1;
	localparam logic       CLIP_EVENT_RST   = 1'h0;
	localparam logic       CLIP_LIVE_RST    = 1'h0;
	localparam logic       CLIP_MASK_RST    = 1'h0;
	localparam logic [7:0] SNIPPET_RST      = 8'h00;
	localparam logic [7:0] READ_ZERO        = 8'h00;

endpackage

// [hdl/hcfg_snippet_mem.sv]
// Purpose: Byte-wide snippet store, one register per byte
// Assumes: Single clock, reset already synchronised by the parent
// Notes:   Two combinational read ports, one write port
module hcfg_snippet_mem
	import hcfg_pkg::*;
#(
	parameter int DEPTH = SNIPPET_BYTES
)
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_wr,
	input  wire logic [6:0] i_wr_idx,
	input  wire logic [7:0] i_wr_data,
	input  wire logic [6:0] i_rd_idx_a,
	output logic      [7:0] o_rd_data_a,
	input  wire logic [6:0] i_rd_idx_b,
	output logic      [7:0] o_rd_data_b
);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	// Index is seven bits wide, so depth beyond 128 cannot be reached
	if (DEPTH < 1 || DEPTH > 128)
	begin : g_bad_depth
		$error("hcfg_snippet_mem: DEPTH out of range");
	end

	typedef struct packed {
		logic [DEPTH-1:0][7:0] bytes;
	} hcfg_mem_state_t;

	hcfg_mem_state_t mem_reg;
	hcfg_mem_state_t mem_next;

	// Write one byte; out-of-range index is ignored
	always_comb
	begin
		mem_next = mem_reg;
		if (i_wr && (int'(i_wr_idx) < DEPTH))
		begin
			mem_next.bytes[i_wr_idx] = i_wr_data;
		end
	end

	// Every byte clears to zero on reset
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mem_reg <= '0;
		end
		else
		begin
			mem_reg <= mem_next;
		end
	end

	// Read ports; out-of-range index reads zero
	always_comb
	begin
		o_rd_data_a = READ_ZERO;
		o_rd_data_b = READ_ZERO;
		if (int'(i_rd_idx_a) < DEPTH)
		begin
			o_rd_data_a = mem_reg.bytes[i_rd_idx_a];
		end
		if (int'(i_rd_idx_b) < DEPTH)
		begin
			o_rd_data_b = mem_reg.bytes[i_rd_idx_b];
		end
	end

endmodule

// [hdl/hcfg_regs.sv]
// Purpose: Configuration, converter-clip fault and snippet register slice
// Assumes: Byte-wide register port synchronous to i_clk, 125 MHz
// Notes:   Read data appears one cycle after the read strobe
module hcfg_regs
	import hcfg_pkg::*;
#(
	parameter int SNIP_DEPTH = SNIPPET_BYTES
)
(
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_rd,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rvalid,
	input  wire logic       i_converter_clip,
	input  wire logic [6:0] i_snippet_idx,
	output logic      [7:0] o_snippet_byte,
	output logic      [1:0] o_high_side_edge_rate,
	output logic            o_delay_bypass,
	output logic            o_freq_hold_on_reversal,
	output logic            o_volt_current_offset_on,
	output logic            o_irq
);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	// The snippet window in the map is fixed at 100 addresses
	if (SNIP_DEPTH != int'(SNIPPET_BYTE_LAST_ADDR - SNIPPET_BYTE_FIRST_ADDR) + 1)
	begin : g_bad_depth
		$error("hcfg_regs: SNIP_DEPTH must match the snippet window");
	end

	typedef struct packed {
		logic [1:0] edge_rate;
		logic       delay_bypass;
		logic       freq_hold;
		logic       offset_on;
		logic       clip_event;
		logic       clip_live;
		logic       clip_mask;
		logic [7:0] rdata;
		logic       rvalid;
	} hcfg_state_t;

	// ****************************************************************
	// Address decode helpers
	// ****************************************************************
	function automatic logic hcfg_is_snippet(input logic [7:0] addr);
		return (addr >= SNIPPET_BYTE_FIRST_ADDR) && (addr <= SNIPPET_BYTE_LAST_ADDR);
	endfunction

	function automatic logic [6:0] hcfg_snippet_index(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - SNIPPET_BYTE_FIRST_ADDR;
		return diff[6:0];
	endfunction

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_meta_reg;
	logic rst_n_reg;

	// Asynchronous assert, release through two flops
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// ****************************************************************
	// Snippet store
	// ****************************************************************
	logic [7:0] snip_host_data;
	logic       snip_wr;
	logic [6:0] snip_idx;

	// Snippet bytes, one address per byte
	// consecutive byte mapping
	assign snip_wr  = i_reg_wr && hcfg_is_snippet(i_reg_addr);
	assign snip_idx = hcfg_snippet_index(i_reg_addr);

	hcfg_snippet_mem #(
		.DEPTH (SNIP_DEPTH)
	) u_snippet_mem (
		.i_clk       (i_clk),
		.i_rst_n     (rst_n_reg),
		.i_wr        (snip_wr),
		.i_wr_idx    (snip_idx),
		.i_wr_data   (i_reg_wdata),
		.i_rd_idx_a  (snip_idx),
		.o_rd_data_a (snip_host_data),
		.i_rd_idx_b  (i_snippet_idx),
		.o_rd_data_b (o_snippet_byte)
	);

	// ****************************************************************
	// Register state
	// ****************************************************************
	hcfg_state_t st_reg;
	hcfg_state_t st_next;
	logic        clip_clear;

	// Write-one-to-clear of the event bit
	assign clip_clear = i_reg_wr && (i_reg_addr == ACTUATOR_FAULT_EVENTS_ADDR)
		&& i_reg_wdata[CLIP_EVENT_BIT];

	// Next-state: writes, fault tracking, read capture
	always_comb
	begin
		st_next        = st_reg;
		st_next.rvalid = i_reg_rd;
		if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				HBRIDGE_EDGE_TRIM_ADDR:
				begin
					st_next.edge_rate = i_reg_wdata[EDGE_RATE_LSB +: 2];
				end
				TOP_CONFIG_FIVE_ADDR:
				begin
					st_next.delay_bypass = i_reg_wdata[DELAY_BYPASS_BIT];
					st_next.freq_hold    = i_reg_wdata[FREQ_HOLD_BIT];
					st_next.offset_on    = i_reg_wdata[OFFSET_ON_BIT];
				end
				IRQ_MASK_SECOND_ADDR:
				begin
					st_next.clip_mask = i_reg_wdata[CLIP_MASK_BIT];
				end
				default:
				begin
					st_next.clip_mask = st_reg.clip_mask;
				end
			endcase
		end
		st_next.clip_live = i_converter_clip;
		if (i_converter_clip)
		begin
			st_next.clip_event = 1'b1;
		end
		else if (clip_clear)
		begin
			st_next.clip_event = 1'b0;
		end
		// Read data; unmapped addresses and reserved bits read zero
		if (i_reg_rd)
		begin
			st_next.rdata = READ_ZERO;
			if (hcfg_is_snippet(i_reg_addr))
			begin
				st_next.rdata = snip_host_data;
			end
			else
			begin
				unique case (i_reg_addr)
					HBRIDGE_EDGE_TRIM_ADDR:
						st_next.rdata[EDGE_RATE_LSB +: 2] = st_reg.edge_rate;
					TOP_CONFIG_FIVE_ADDR:
					begin
						st_next.rdata[DELAY_BYPASS_BIT] = st_reg.delay_bypass;
						st_next.rdata[FREQ_HOLD_BIT]    = st_reg.freq_hold;
						st_next.rdata[OFFSET_ON_BIT]    = st_reg.offset_on;
					end
					ACTUATOR_FAULT_EVENTS_ADDR:
						st_next.rdata[CLIP_EVENT_BIT] = st_reg.clip_event;
					IRQ_STATUS_SECOND_ADDR:
						st_next.rdata[CLIP_LIVE_BIT] = st_reg.clip_live;
					IRQ_MASK_SECOND_ADDR:
						st_next.rdata[CLIP_MASK_BIT] = st_reg.clip_mask;
					default:
						st_next.rdata = READ_ZERO;
				endcase
			end
		end
	end

	// State register with documented reset values
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			st_reg.edge_rate    <= EDGE_RATE_RST;
			st_reg.delay_bypass <= DELAY_BYPASS_RST;
			st_reg.freq_hold    <= FREQ_HOLD_RST;
			st_reg.offset_on    <= OFFSET_ON_RST;
			st_reg.clip_event   <= CLIP_EVENT_RST;
			st_reg.clip_live    <= CLIP_LIVE_RST;
			st_reg.clip_mask    <= CLIP_MASK_RST;
			st_reg.rdata        <= READ_ZERO;
			st_reg.rvalid       <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_reg_rdata              = st_reg.rdata;
	assign o_reg_rvalid             = st_reg.rvalid;
	assign o_high_side_edge_rate    = st_reg.edge_rate;
	assign o_delay_bypass           = st_reg.delay_bypass;
	assign o_freq_hold_on_reversal  = st_reg.freq_hold;
	assign o_volt_current_offset_on = st_reg.offset_on;

	// Level interrupt; masking hides it but keeps the event pending
	// unmasked pending event
	assign o_irq = st_reg.clip_event && !st_reg.clip_mask;

endmodule

// [verif/hcfg_regs_assertions.sv]
// Purpose: Port checks for the config and clip fault slice
// Assumes: One clock, async active-low reset
// Notes:   Bound to hcfg_regs from the testbench file
module hcfg_regs_chk
	import hcfg_pkg::*;
#(
	parameter int SNIP_DEPTH = SNIPPET_BYTES
)
(
	input wire logic       i_clk,
	input wire logic       i_arst_n,
	input wire logic [7:0] i_reg_addr,
	input wire logic       i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic       i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       o_reg_rvalid,
	input wire logic       i_converter_clip,
	input wire logic [6:0] i_snippet_idx,
	input wire logic [7:0] o_snippet_byte,
	input wire logic [1:0] o_high_side_edge_rate,
	input wire logic       o_delay_bypass,
	input wire logic       o_freq_hold_on_reversal,
	input wire logic       o_volt_current_offset_on,
	input wire logic       o_irq
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	wire logic [2:0] cfg_bits = {o_delay_bypass, o_freq_hold_on_reversal, o_volt_current_offset_on};
	wire logic       cfg_wr   = i_reg_wr && i_reg_addr == TOP_CONFIG_FIVE_ADDR;
	wire logic       mask_wr  = i_reg_wr && i_reg_addr == IRQ_MASK_SECOND_ADDR;

	// Clip seen, then a read of a given register
	sequence s_rd(a);
		i_reg_rd && i_reg_addr == a;
	endsequence
	sequence s_clip_rd(a);
		i_converter_clip ##1 s_rd(a);
	endsequence

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_read_answers: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read strobe got no answer");
	a_no_stray_valid: assert property (!i_reg_rd |=> !o_reg_rvalid)
		else $error("answer without read strobe");
	a_unmapped_zero: assert property (s_rd(8'he8) |=> o_reg_rdata == READ_ZERO)
		else $error("unmapped read not zero");
	a_trim_write: assert property (i_reg_wr && i_reg_addr == HBRIDGE_EDGE_TRIM_ADDR
		|=> o_high_side_edge_rate == $past(i_reg_wdata[1:0]))
		else $error("edge rate not written");
	a_cfg_write: assert property (cfg_wr |=> cfg_bits == $past(i_reg_wdata[2:0]))
		else $error("config bits not written");
	a_cfg_steady: assert property (!cfg_wr |=> $stable(cfg_bits))
		else $error("config bits moved without write");
	a_event_sticky: assert property (s_clip_rd(ACTUATOR_FAULT_EVENTS_ADDR)
		|=> o_reg_rdata[CLIP_EVENT_BIT])
		else $error("clip event not set");
	a_status_live: assert property (s_clip_rd(IRQ_STATUS_SECOND_ADDR)
		|=> o_reg_rdata[CLIP_LIVE_BIT])
		else $error("clip status not shown");
	a_mask_hides: assert property (mask_wr && i_reg_wdata[7] |=> !o_irq)
		else $error("masked clip still interrupts");
	a_irq_raise: assert property (mask_wr && !i_reg_wdata[7] && i_converter_clip |=> o_irq)
		else $error("unmasked clip gives no interrupt");
	a_snip_write: assert property (i_reg_wr && i_reg_addr == SNIPPET_BYTE_FIRST_ADDR
		&& i_snippet_idx == 7'h00 |=> i_snippet_idx != 7'h00
		|| o_snippet_byte == $past(i_reg_wdata))
		else $error("snippet byte 0 not written");
endmodule

// [verif/hcfg_tb.sv]
// Purpose: Register-level test of hcfg_regs
// Assumes: Strobe register port, read answer one cycle later
// Notes:   Inputs change 1 ns after the rising edge
module testbench
	import hcfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       clip = 1'b0;
	logic [6:0] idx = 7'h00;
	logic [7:0] rdata;
	logic [7:0] sbyte;
	logic [1:0] rate;
	logic       rvalid, byp, hold, ofs, irq;
	int         mismatches = 0;
	int         samples_checked = 0;

	// 125 MHz clock
	always #4 clk = ~clk;

	hcfg_regs #(.SNIP_DEPTH(SNIPPET_BYTES)) dut_u (.i_clk(clk), .i_arst_n(arst_n),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_converter_clip(clip),
		.i_snippet_idx(idx), .o_snippet_byte(sbyte), .o_high_side_edge_rate(rate),
		.o_delay_bypass(byp), .o_freq_hold_on_reversal(hold),
		.o_volt_current_offset_on(ofs), .o_irq(irq));

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		#1;
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		wr = 1'b0;
	endtask
	// Strobe one cycle, answer is valid right after the next edge
	task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
		@(posedge clk);
		#1;
		rd = 1'b1;
		addr = a;
		@(posedge clk);
		#1;
		rd = 1'b0;
		check("rvalid", {7'h00, rvalid}, 8'h01);
		check("rdata", rdata, exp);
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		arst_n = 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(HBRIDGE_EDGE_TRIM_ADDR, 8'h03);
		rd_reg(TOP_CONFIG_FIVE_ADDR, 8'h01);
		rd_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'h00);
		rd_reg(IRQ_STATUS_SECOND_ADDR, 8'h00);
		rd_reg(IRQ_MASK_SECOND_ADDR, 8'h00);
		rd_reg(SNIPPET_BYTE_LAST_ADDR, 8'h00);
		$display("test reset done");
		for (int k = 0; k < 4; k++)
		begin
			wr_reg(HBRIDGE_EDGE_TRIM_ADDR, 8'(k));
			check("rate", {6'h00, rate}, 8'(k));
		end
		wr_reg(TOP_CONFIG_FIVE_ADDR, 8'h06);
		check("cfg", {5'h00, byp, hold, ofs}, 8'h06);
		wr_reg(TOP_CONFIG_FIVE_ADDR, 8'hf9);
		rd_reg(TOP_CONFIG_FIVE_ADDR, 8'h01);
		$display("test config done");
		for (int i = 0; i < SNIPPET_BYTES; i++)
			wr_reg(SNIPPET_BYTE_FIRST_ADDR + 8'(i), 8'(i * 37 + 5));
		for (int i = 0; i < SNIPPET_BYTES; i++)
		begin
			idx = 7'(i);
			rd_reg(SNIPPET_BYTE_FIRST_ADDR + 8'(i), 8'(i * 37 + 5));
			check("snippet", sbyte, 8'(i * 37 + 5));
		end
		// Consumer index past the last byte reads zero
		idx = 7'h64;
		rd_reg(8'he8, READ_ZERO);
		check("snippet", sbyte, READ_ZERO);
		$display("test snippet done");
		// Clip held across two reads
		clip = 1'b1;
		rd_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'h04);
		rd_reg(IRQ_STATUS_SECOND_ADDR, 8'h80);
		check("irq", {7'h00, irq}, 8'h01);
		clip = 1'b0;
		wr_reg(IRQ_STATUS_SECOND_ADDR, 8'hff);
		rd_reg(IRQ_STATUS_SECOND_ADDR, 8'h00);
		wr_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'hfb);
		rd_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'h04);
		wr_reg(IRQ_MASK_SECOND_ADDR, 8'h80);
		check("irq", {7'h00, irq}, 8'h00);
		rd_reg(IRQ_MASK_SECOND_ADDR, 8'h80);
		wr_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'h04);
		rd_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'h00);
		clip = 1'b1;
		wr_reg(IRQ_MASK_SECOND_ADDR, 8'h00);
		check("irq", {7'h00, irq}, 8'h01);
		clip = 1'b0;
		wr_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'h04);
		check("irq", {7'h00, irq}, 8'h00);
		// Clip in the same cycle as the clear: set must win
		clip = 1'b1;
		wr_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'h04);
		clip = 1'b0;
		rd_reg(ACTUATOR_FAULT_EVENTS_ADDR, 8'h04);
		$display("test clip done");
		end_of_test();
	end

	// Run needs under 700 cycles, so this only trips on a hang
	initial
	begin
		#50000;
		mismatches++;
		end_of_test();
	end
endmodule

bind hcfg_regs hcfg_regs_chk #(.SNIP_DEPTH(SNIP_DEPTH)) chk_u (
	.i_clk                    (i_clk),
	.i_arst_n                 (i_arst_n),
	.i_reg_addr               (i_reg_addr),
	.i_reg_wr                 (i_reg_wr),
	.i_reg_wdata              (i_reg_wdata),
	.i_reg_rd                 (i_reg_rd),
	.o_reg_rdata              (o_reg_rdata),
	.o_reg_rvalid             (o_reg_rvalid),
	.i_converter_clip         (i_converter_clip),
	.i_snippet_idx            (i_snippet_idx),
	.o_snippet_byte           (o_snippet_byte),
	.o_high_side_edge_rate    (o_high_side_edge_rate),
	.o_delay_bypass           (o_delay_bypass),
	.o_freq_hold_on_reversal  (o_freq_hold_on_reversal),
	.o_volt_current_offset_on (o_volt_current_offset_on),
	.o_irq                    (o_irq)
);
